/* File: core/bas_execute.sv */
// execute stage: conditional jumps, data-processing alu, barrel shifter, status registers
//
// How it works
// - run only when condition passes flags
// - offset shifted two, sign-extended, added
// - incoming pc is eight bytes ahead
// - call writes following address, no status
// - plain jump leaves link register alone
// - taken jump costs three cycles
// - operand two: shifted register or immediate
// - flags change only with set bit or a test op
// - test ops set flags, never write
// - and, exclusive-or, inclusive-or bitwise
// - bit clear, copy, copy inverted
// - difference, reverse difference and sum
// - carry-in forms of add and subtract
// - test ops evaluate like logic/arith
// - logical flags use shifter carry
// - arithmetic flags use alu carry, overflow
// - four shift kinds, immediate or register
// - immediate amount five bits, 0..31
// - left shift zero fill, carry last out
// - right zero means 32, rotate extended
// - register amount zero passes, old carry
// - register amounts 32 and above
// - pc destination with set restores status
//
// Decided for this implementation: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
module bas_execute (
  input wire logic ref_clk_i, // processor clock
  input wire logic rst_b_i, // synchronous reset, low active
  input wire bas_pkg::bas_req_s req_i, // decoded instruction
  output var logic ready_o, // request may be taken
  output var bas_pkg::bas_rsp_s rsp_o, // results and jump
  output var logic [31:0] csw_o, // current status word
  input wire bas_pkg::bas_bus_s bus_i, // register port
  output var logic [31:0] rd_data_o // read data, cycle after
);
  import bas_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // helper functions
  // condition field against n z c v; never code reads false
  function automatic logic cond_pass(input logic [3:0] cc, input logic [3:0] f);
    logic r;
    r = 1'b1;
    case (cc[3:1])
      3'h0: r = f[2];
      3'h1: r = f[1];
      3'h2: r = f[3];
      3'h3: r = f[0];
      3'h4: r = f[1] & ~f[2];
      3'h5: r = (f[3] == f[0]);
      3'h6: r = ~f[2] & (f[3] == f[0]);
      default: r = 1'b1;
    endcase
    return r ^ cc[0];
  endfunction

  // barrel shifter, returns {carry, value}; amount zero passes value
  function automatic logic [32:0] shift_fn(input bas_shf_e kind, input logic [7:0] amt,
                                           input logic [31:0] v, input logic cin);
    logic [32:0] t, w;
    logic [31:0] rot;
    logic [4:0] a5;
    t = {cin, v};
    w = 33'h0;
    rot = 32'h0;
    a5 = amt[4:0];
    if (amt != 8'h00) begin
      case (kind)
        SHF_LEFT_LOGICAL: begin
          if (amt < 8'h20) begin
            w = {1'b0, v} << a5;
            t = w;
          end else if (amt == 8'h20) begin
            t = {v[0], 32'h0};
          end else begin
            t = 33'h0;
          end
        end
        SHF_RIGHT_LOGICAL: begin
          if (amt < 8'h20) begin
            w = {v, 1'b0} >> a5;
            t = {w[0], w[32:1]};
          end else if (amt == 8'h20) begin
            t = {v[31], 32'h0};
          end else begin
            t = 33'h0;
          end
        end
        SHF_RIGHT_ARITH: begin
          if (amt < 8'h20) begin
            w = $signed({v, 1'b0}) >>> a5;
            t = {w[0], w[32:1]};
          end else begin
            t = {v[31], {32{v[31]}}};
          end
        end
        default: begin
          if (a5 == 5'h00) begin
            t = {v[31], v};
          end else begin
            rot = (v >> a5) | (v << (6'd32 - {1'b0, a5}));
            t = {rot[31], rot};
          end
        end
      endcase
    end
    return t;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // state
  bas_st_e st_q, st_d;
  logic ready_q, rserr_q;
  logic [31:0] csw_q, csw_d, ssw_q, res_q, rd_q, rd_d;
  bas_rsp_s rsp_q, rsp_d;

  ////////////////////////////////////////////////////////////////////////
  // decode and datapath
  logic take, is_jump, is_dp, cond_ok, use_imm, reg_shift, rs_bad, exec_jump, exec_dp;
  logic set_flags, is_test, arith, pc_dest, cin, shc, aci, ovf;
  logic [3:0] rd_idx, nzcv;
  bas_opc_e opc;
  bas_shf_e kind;
  logic [4:0] imm_amt;
  logic [7:0] amt;
  logic [5:0] rot2;
  logic [32:0] shout, sum;
  logic [31:0] immv, op2, ax, ay, res, offs;

  // instruction classes and guards
  always_comb begin
    take = req_i.valid & ready_q;
    is_jump = (req_i.instr[27:25] == 3'b101);
    is_dp = (req_i.instr[27:26] == 2'b00);
    cond_ok = cond_pass(req_i.instr[BAS_F_COND_HI:BAS_F_COND_LO], csw_q[BAS_FLAGS_HI:BAS_FLAGS_LO]);
    use_imm = req_i.instr[BAS_F_IMM];
    reg_shift = ~use_imm & req_i.instr[BAS_F_REGSHIFT];
    rs_bad = is_dp & reg_shift & (req_i.instr[11:8] == BAS_PC_IDX);
    exec_jump = take & is_jump & cond_ok;
    exec_dp = take & is_dp & cond_ok & ~rs_bad;
    opc = bas_opc_e'(req_i.instr[BAS_F_OPC_HI:BAS_F_OPC_LO]);
    is_test = (req_i.instr[24:23] == 2'b10);
    set_flags = req_i.instr[BAS_F_SET] | is_test;
    rd_idx = req_i.instr[15:12];
    pc_dest = (rd_idx == BAS_PC_IDX) & ~is_test;
    cin = csw_q[BAS_FLAGS_LO + 1];
  end

  // second operand: shifted register or rotated immediate
  always_comb begin
    kind = bas_shf_e'(req_i.instr[6:5]);
    imm_amt = req_i.instr[11:7];
    amt = {3'b000, imm_amt};
    if (reg_shift) begin
      amt = req_i.rs[7:0];
    end else if (imm_amt == 5'h00 && kind != SHF_LEFT_LOGICAL) begin
      amt = 8'h20;
    end
    shout = shift_fn(kind, amt, req_i.rm, cin);
    if (~reg_shift && imm_amt == 5'h00 && kind == SHF_ROTATE_RIGHT) begin
      shout = {req_i.rm[0], cin, req_i.rm[31:1]};
    end
    rot2 = {1'b0, req_i.instr[11:8], 1'b0};
    immv = ({24'h0, req_i.instr[7:0]} >> rot2) | ({24'h0, req_i.instr[7:0]} << (6'd32 - rot2));
    if (use_imm) begin
      op2 = immv;
      shc = (rot2 == 6'h00) ? cin : immv[31];
    end else begin
      op2 = shout[31:0];
      shc = shout[32];
    end
  end

  // alu; first adder operand from first operand register, except reverse differences, which take operand two
  always_comb begin
    ax = req_i.op1;
    ay = op2;
    aci = 1'b0;
    arith = 1'b1;
    res = 32'h0;
    case (opc)
      OPC_AND, OPC_TEST_BITS: begin
        arith = 1'b0;
        res = req_i.op1 & op2;
      end
      OPC_EXCL_OR, OPC_TEST_EQUIV: begin
        arith = 1'b0;
        res = req_i.op1 ^ op2;
      end
      OPC_DIFF, OPC_COMPARE: begin
        ay = ~op2;
        aci = 1'b1;
      end
      OPC_REV_DIFF: begin
        ax = op2;
        ay = ~req_i.op1;
        aci = 1'b1;
      end
      OPC_ADD_CARRY: begin
        aci = cin;
      end
      OPC_DIFF_CARRY: begin
        ay = ~op2;
        aci = cin;
      end
      OPC_REV_DIFF_CARRY: begin
        ax = op2;
        ay = ~req_i.op1;
        aci = cin;
      end
      OPC_INCL_OR: begin
        arith = 1'b0;
        res = req_i.op1 | op2;
      end
      OPC_COPY: begin
        arith = 1'b0;
        res = op2;
      end
      OPC_BIT_CLEAR: begin
        arith = 1'b0;
        res = req_i.op1 & ~op2;
      end
      OPC_COPY_INV: begin
        arith = 1'b0;
        res = ~op2;
      end
      default: aci = 1'b0; // plain sum and negated compare
    endcase
    sum = {1'b0, ax} + {1'b0, ay} + {32'h0, aci};
    ovf = (ax[31] == ay[31]) & (sum[31] != ax[31]);
    if (arith) begin
      res = sum[31:0];
      nzcv = {sum[31], (sum[31:0] == 32'h0), sum[32], ovf};
    end else begin
      nzcv = {res[31], (res == 32'h0), shc, csw_q[BAS_FLAGS_LO]};
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // answer to register bank and fetch
  // jump offset: shift two, sign extend
  assign offs = {{6{req_i.instr[23]}}, req_i.instr[23:0], 2'b00};

  always_comb begin
    rsp_d = '0;
    if (exec_jump) begin
      rsp_d.jump = 1'b1;
      rsp_d.target = req_i.pc + offs;
      rsp_d.link_en = req_i.instr[BAS_F_LINK];
      rsp_d.link = req_i.pc - BAS_PREFETCH_BYTES + BAS_WORD_BYTES;
    end else if (exec_dp && !is_test) begin
      if (pc_dest) begin
        rsp_d.jump = 1'b1;
        rsp_d.target = res;
      end else begin
        rsp_d.wr_en = 1'b1;
        rsp_d.dest = rd_idx;
        rsp_d.value = res;
      end
    end
  end

  // response register
  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      rsp_q <= '0;
    end else begin
      rsp_q <= rsp_d;
    end
  end

  // last executed data-processing result
  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      res_q <= BAS_RES_RST;
    end else if (exec_dp) begin
      res_q <= res;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // issue control: refill after a taken jump
  always_comb begin
    st_d = st_q;
    case (st_q)
      BAS_ST_RUN: begin
        if (exec_jump || (exec_dp && pc_dest)) begin
          st_d = BAS_ST_REFILL_S;
        end
      end
      BAS_ST_REFILL_S: st_d = BAS_ST_REFILL_N;
      BAS_ST_REFILL_N: st_d = BAS_ST_RUN;
      default: st_d = BAS_ST_RUN;
    endcase
  end

  // state and ready flag
  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      st_q <= BAS_ST_RUN;
      ready_q <= 1'b1;
    end else begin
      st_q <= st_d;
      ready_q <= (st_d == BAS_ST_RUN);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // status words; hardware flag update wins over a software write
  always_comb begin
    csw_d = csw_q;
    if (bus_i.wr && bus_i.addr == BAS_OFS_CSW) begin
      csw_d = bus_i.wdata;
    end
    if (exec_dp && set_flags) begin
      if (pc_dest) begin
        csw_d = ssw_q;
      end else begin
        csw_d[BAS_FLAGS_HI:BAS_FLAGS_LO] = nzcv;
      end
    end
  end

  // current status word
  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      csw_q <= BAS_CSW_RST;
    end else begin
      csw_q <= csw_d;
    end
  end

  // saved status word of the current mode
  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      ssw_q <= BAS_SSW_RST;
    end else if (bus_i.wr && bus_i.addr == BAS_OFS_SSW) begin
      ssw_q <= bus_i.wdata;
    end
  end

  // sticky bad shift register flag, write one clears, set wins
  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      rserr_q <= 1'b0;
    end else if (take && is_dp && cond_ok && rs_bad) begin
      rserr_q <= 1'b1;
    end else if (bus_i.wr && bus_i.addr == BAS_OFS_STAT && bus_i.wdata[BAS_STAT_RSERR]) begin
      rserr_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // register read port, data in the cycle after the strobe only
  always_comb begin
    rd_d = 32'h0;
    if (bus_i.rd) begin
      case (bus_i.addr)
        BAS_OFS_CSW: rd_d = csw_q;
        BAS_OFS_SSW: rd_d = ssw_q;
        BAS_OFS_STAT: begin
          rd_d[BAS_STAT_READY] = ready_q;
          rd_d[BAS_STAT_RSERR] = rserr_q;
        end
        BAS_OFS_RES: rd_d = res_q;
        default: rd_d = 32'h0;
      endcase
    end
  end

  // read data register
  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      rd_q <= 32'h0;
    end else begin
      rd_q <= rd_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs straight from flip-flops
  assign ready_o = ready_q;
  assign rsp_o = rsp_q;
  assign csw_o = csw_q;
  assign rd_data_o = rd_q;
endmodule
`default_nettype wire

/* File: core/bas_pkg.sv */
// shared constants, encodings and carrier types of the branch alu shifter execute block
package bas_pkg;
  // register byte offsets on the plain register port
  localparam logic [3:0] BAS_OFS_CSW = 4'h0;
  localparam logic [3:0] BAS_OFS_SSW = 4'h4;
  localparam logic [3:0] BAS_OFS_STAT = 4'h8;
  localparam logic [3:0] BAS_OFS_RES = 4'hc;
  // values after reset
  localparam logic [31:0] BAS_CSW_RST = 32'h0000_00d3;
  localparam logic [31:0] BAS_SSW_RST = 32'h0000_0000;
  localparam logic [31:0] BAS_RES_RST = 32'h0000_0000;
  // status word flag field, n z c v from top down
  localparam int BAS_FLAGS_HI = 31;
  localparam int BAS_FLAGS_LO = 28;
  // status register bit positions
  localparam int BAS_STAT_READY = 0;
  localparam int BAS_STAT_RSERR = 1;
  // instruction field positions
  localparam int BAS_F_COND_HI = 31;
  localparam int BAS_F_COND_LO = 28;
  localparam int BAS_F_IMM = 25;
  localparam int BAS_F_LINK = 24;
  localparam int BAS_F_OPC_HI = 24;
  localparam int BAS_F_OPC_LO = 21;
  localparam int BAS_F_SET = 20;
  localparam int BAS_F_REGSHIFT = 4;
  // prefetch distance and word size in bytes
  localparam logic [31:0] BAS_PREFETCH_BYTES = 32'h0000_0008;
  localparam logic [31:0] BAS_WORD_BYTES = 32'h0000_0004;
  // register index of the program counter
  localparam logic [3:0] BAS_PC_IDX = 4'hf;
  // cycles taken by a taken jump: two sequential plus one non-sequential
  localparam int BAS_JUMP_CYCLES = 3;
  // data-processing operation codes
  typedef enum logic [3:0] {
    OPC_AND = 4'b0000,
    OPC_EXCL_OR = 4'b0001,
    OPC_DIFF = 4'b0010,
    OPC_REV_DIFF = 4'b0011,
    OPC_ADD = 4'b0100,
    OPC_ADD_CARRY = 4'b0101,
    OPC_DIFF_CARRY = 4'b0110,
    OPC_REV_DIFF_CARRY = 4'b0111,
    OPC_TEST_BITS = 4'b1000,
    OPC_TEST_EQUIV = 4'b1001,
    OPC_COMPARE = 4'b1010,
    OPC_COMPARE_NEG = 4'b1011,
    OPC_INCL_OR = 4'b1100,
    OPC_COPY = 4'b1101,
    OPC_BIT_CLEAR = 4'b1110,
    OPC_COPY_INV = 4'b1111
  } bas_opc_e;
  // shift types
  typedef enum logic [1:0] {
    SHF_LEFT_LOGICAL = 2'b00,
    SHF_RIGHT_LOGICAL = 2'b01,
    SHF_RIGHT_ARITH = 2'b10,
    SHF_ROTATE_RIGHT = 2'b11
  } bas_shf_e;
  // issue states
  typedef enum logic [1:0] {
    BAS_ST_RUN = 2'b00,
    BAS_ST_REFILL_S = 2'b01,
    BAS_ST_REFILL_N = 2'b10
  } bas_st_e;
  // request from fetch and decode
  typedef struct packed {
    logic valid;
    logic [31:0] instr;
    logic [31:0] pc;
    logic [31:0] op1;
    logic [31:0] rm;
    logic [31:0] rs;
  } bas_req_s;
  // answer to the register bank and fetch
  typedef struct packed {
    logic wr_en;
    logic [3:0] dest;
    logic [31:0] value;
    logic link_en;
    logic [31:0] link;
    logic jump;
    logic [31:0] target;
  } bas_rsp_s;
  // register port request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [3:0] addr;
    logic [31:0] wdata;
  } bas_bus_s;
endpackage

/* File: tb/bas_monitor.sv */
// concurrent checks on the execute block ports
`timescale 1ns/1ps
`default_nettype none
module bas_monitor (
  input wire logic ref_clk_i, // clock
  input wire logic rst_b_i, // reset, low
  input wire bas_pkg::bas_req_s req_i, // request
  input wire logic ready_o, // ready
  input wire bas_pkg::bas_rsp_s rsp_o, // answer
  input wire logic [31:0] csw_o, // status word
  input wire bas_pkg::bas_bus_s bus_i, // register port
  input wire logic [31:0] rd_data_o // read data
);
  import bas_pkg::*;
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rst_b_i);
  ////////////////////////////////////////////////////////////////
  // decode of the request being taken, always condition only
  logic take, jmp, dp, setb, tst, pcd, lgc;
  logic [63:0] imm_rot;
  assign take = req_i.valid && ready_o;
  assign jmp = take && req_i.instr[31:28] == 4'he && req_i.instr[27:25] == 3'b101;
  assign dp = take && req_i.instr[31:28] == 4'he && req_i.instr[27:26] == 2'b00 &&
              (req_i.instr[25] || !req_i.instr[4] || req_i.instr[11:8] != 4'hf);
  assign setb = req_i.instr[20];
  assign tst = req_i.instr[24:23] == 2'b10;
  assign pcd = req_i.instr[15:12] == 4'hf;
  assign lgc = req_i.instr[23:22] == 2'b00 || req_i.instr[24:23] == 2'b11;
  assign imm_rot = {2{24'h000000, req_i.instr[7:0]}} >> {req_i.instr[11:8], 1'b0};
  ////////////////////////////////////////////////////////////////
  // jump answers and refill gap
  sequence s_refill;
    !ready_o [*2] ##1 ready_o;
  endsequence
  property p_target;
    jmp |=> rsp_o.jump && rsp_o.target == $past(req_i.pc) +
      {{6{$past(req_i.instr[23])}}, $past(req_i.instr[23:0]), 2'b00};
  endproperty
  a_target: assert property (p_target) else $error("jump target wrong");
  property p_link;
    jmp && req_i.instr[24] |=> rsp_o.link_en && rsp_o.link == $past(req_i.pc) - 32'h0000_0004;
  endproperty
  a_link: assert property (p_link) else $error("link value wrong");
  property p_nolink;
    jmp && !req_i.instr[24] |=> !rsp_o.link_en;
  endproperty
  a_nolink: assert property (p_nolink) else $error("link written by plain jump");
  property p_refill;
    jmp |=> s_refill;
  endproperty
  a_refill: assert property (p_refill) else $error("jump cycle count wrong");
  property p_never;
    take && req_i.instr[31:28] == 4'hf && !bus_i.wr |=> rsp_o == '0 && csw_o == $past(csw_o);
  endproperty
  a_never: assert property (p_never) else $error("failed condition had effect");
  ////////////////////////////////////////////////////////////////
  // data-processing answers and flags
  property p_keep;
    dp && !setb && !tst && !pcd && !bus_i.wr |=> csw_o[31:28] == $past(csw_o[31:28]);
  endproperty
  a_keep: assert property (p_keep) else $error("flags changed without set bit");
  property p_test;
    dp && tst |=> !rsp_o.wr_en;
  endproperty
  a_test: assert property (p_test) else $error("test op wrote result");
  property p_imm;
    dp && req_i.instr[25] && req_i.instr[24:21] == 4'b1101 && !pcd |=>
      rsp_o.wr_en && rsp_o.value == $past(imm_rot[31:0]);
  endproperty
  a_imm: assert property (p_imm) else $error("immediate operand wrong");
  property p_lflags;
    dp && setb && lgc && !tst && !pcd && !bus_i.wr |=> csw_o[28] == $past(csw_o[28]) &&
      csw_o[31] == rsp_o.value[31] && csw_o[30] == (rsp_o.value == 32'h0);
  endproperty
  a_lflags: assert property (p_lflags) else $error("logical flags wrong");
  property p_pcdest;
    dp && !tst && pcd |=> rsp_o.jump && !rsp_o.wr_en ##0 s_refill;
  endproperty
  a_pcdest: assert property (p_pcdest) else $error("pc destination not a jump");
endmodule
bind bas_execute bas_monitor i_mon (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .req_i(req_i),
  .ready_o(ready_o), .rsp_o(rsp_o), .csw_o(csw_o), .bus_i(bus_i), .rd_data_o(rd_data_o));
`default_nettype wire

/* File: tb/bas_fetch_model.sv */
// behavioural fetch and decode stage feeding the execute block
`timescale 1ns/1ps
`default_nettype none
module bas_fetch_model (
  input wire logic ref_clk_i, // clock
  input wire logic rst_b_i, // reset, low
  input wire logic ready_i, // execute may take
  input wire logic go_i, // present cmd_i
  input wire bas_pkg::bas_req_s cmd_i, // instruction to issue
  output var bas_pkg::bas_req_s req_o // request to execute
);
  import bas_pkg::*;
  // hold until taken, then scramble the released fields
  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      req_o <= '0;
    end else if (req_o.valid && ready_i) begin
      req_o <= '{valid: 1'b0, instr: ~req_o.instr, pc: ~req_o.pc, op1: ~req_o.op1, rm: ~req_o.rm,
                 rs: ~req_o.rs};
    end else if (go_i) begin
      req_o <= cmd_i;
    end
  end
endmodule
`default_nettype wire

/* File: tb/tb.sv */
// self-checking bench of the execute block
`timescale 1ns/1ps
`default_nettype none
module tb;
  import bas_pkg::*;
  logic ref_clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic go = 1'b0;
  logic ready;
  logic [31:0] csw, rdat, rv, res;
  logic [3:0] fl;
  bas_req_s cmd = '0;
  bas_req_s req;
  bas_rsp_s rsp, got;
  bas_bus_s bus = '0;
  int error_cnt = 0;
  int cmp_count = 0;
  ////////////////////////////////////////////////////////////////
  // clock and instances
  always #2 ref_clk_i = ~ref_clk_i;
  bas_execute i_dut (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .req_i(req), .ready_o(ready),
    .rsp_o(rsp), .csw_o(csw), .bus_i(bus), .rd_data_o(rdat));
  bas_fetch_model i_fetch (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .ready_i(ready), .go_i(go),
    .cmd_i(cmd), .req_o(req));
  ////////////////////////////////////////////////////////////////
  // compare, register port and issue tasks
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge ref_clk_i);
    bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge ref_clk_i);
    bus <= '0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge ref_clk_i);
    bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
    @(posedge ref_clk_i);
    bus <= '0;
    #1 d = rdat;
  endtask
  task automatic ex(input logic [31:0] ins, input logic [31:0] a, input logic [31:0] m, input logic [31:0] s);
    int n;
    n = 0;
    @(posedge ref_clk_i);
    cmd <= '{valid: 1'b1, instr: ins, pc: 32'h0000_1008, op1: a, rm: m, rs: s};
    go <= 1'b1;
    @(posedge ref_clk_i);
    go <= 1'b0;
    #1;
    while (ready !== 1'b1 && n < 20) begin
      @(posedge ref_clk_i);
      #1;
      n++;
    end
    if (n == 20) error_cnt++;
    @(posedge ref_clk_i);
    #1 got = rsp;
    repeat (BAS_JUMP_CYCLES) @(posedge ref_clk_i);
  endtask
  // copy op with set bit through the shifter, old carry one
  task automatic sh(input logic i, input logic [11:0] f, input logic [31:0] m, input logic [31:0] s,
    input logic [31:0] v, input logic c);
    wr(BAS_OFS_CSW, 32'h2000_00d3);
    ex({4'he, 2'b00, i, 4'b1101, 1'b1, 4'h0, 4'h3, f}, 32'h0, m, s);
    chk("shift value", got.value, v);
    chk("shift carry", csw[29], c);
    chk("shift n z", csw[31:30], {v[31], v == 32'h0});
  endtask
  ////////////////////////////////////////////////////////////////
  // expected alu result and flags n z c v
  function automatic logic [35:0] alu(input logic [3:0] op, input logic [31:0] a, input logic [31:0] b,
    input logic [3:0] f);
    logic [32:0] s;
    logic [31:0] x, y, r;
    logic ci, v, ar;
    ar = op[3:2] != 2'b11 && op[2:1] != 2'b00;
    case (op)
      4'b0010, 4'b1010: {x, y, ci} = {a, ~b, 1'b1};
      4'b0011: {x, y, ci} = {b, ~a, 1'b1};
      4'b0101: {x, y, ci} = {a, b, f[1]};
      4'b0110: {x, y, ci} = {a, ~b, f[1]};
      4'b0111: {x, y, ci} = {b, ~a, f[1]};
      default: {x, y, ci} = {a, b, 1'b0};
    endcase
    s = {1'b0, x} + {1'b0, y} + {32'h0, ci};
    v = x[31] == y[31] && s[31] != x[31];
    case (op)
      4'b0000, 4'b1000: r = a & b;
      4'b0001, 4'b1001: r = a ^ b;
      4'b1100: r = a | b;
      4'b1101: r = b;
      4'b1110: r = a & ~b;
      4'b1111: r = ~b;
      default: r = s[31:0];
    endcase
    return {r[31], r == 32'h0, ar ? s[32] : f[1], ar ? v : f[0], r};
  endfunction
  function automatic logic cond_ok(input logic [3:0] c, input logic [3:0] f);
    logic r;
    case (c[3:1])
      3'd0: r = f[2];
      3'd1: r = f[1];
      3'd2: r = f[3];
      3'd3: r = f[0];
      3'd4: r = f[1] && !f[2];
      3'd5: r = f[3] == f[0];
      3'd6: r = !f[2] && f[3] == f[0];
      default: r = 1'b1;
    endcase
    return c == 4'hf ? 1'b0 : r ^ c[0];
  endfunction
  ////////////////////////////////////////////////////////////////
  // verdict and watchdog
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  initial begin
    #100000;
    error_cnt++;
    give_verdict;
  end
  ////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    repeat (3) @(posedge ref_clk_i);
    rst_b_i <= 1'b1;
    rd(BAS_OFS_CSW, rv); chk("csw reset", rv, BAS_CSW_RST);
    rd(BAS_OFS_SSW, rv); chk("ssw reset", rv, BAS_SSW_RST);
    rd(BAS_OFS_RES, rv); chk("res reset", rv, BAS_RES_RST);
    rd(BAS_OFS_STAT, rv); chk("stat reset", rv, 32'h0000_0001);
    rd(4'h2, rv); chk("unmapped", rv, 32'h0);
    for (int s = 0; s < 2; s++) begin
      for (int op = 0; op < 16; op++) begin
        wr(BAS_OFS_CSW, 32'h2000_00d3);
        ex({4'he, 3'b000, op[3:0], s[0], 4'h1, 4'h2, 12'h003}, 32'h7fff_fff0, 32'h0000_0020, 32'h0);
        {fl, res} = alu(op[3:0], 32'h7fff_fff0, 32'h0000_0020, 4'b0010);
        rd(BAS_OFS_RES, rv); chk("result", rv, res);
        chk("write", got.wr_en, op[3:2] != 2'b10);
        chk("dest", got.dest, op[3:2] != 2'b10 ? 32'h2 : 32'h0);
        chk("flags", csw[31:28], (s == 1 || op[3:2] == 2'b10) ? fl : 4'b0010);
      end
    end
    sh(1'b0, 12'h200, 32'hf000_000f, 32'h0, 32'h0000_00f0, 1'b1);
    sh(1'b0, 12'hf80, 32'h0000_0003, 32'h0, 32'h8000_0000, 1'b1);
    sh(1'b0, 12'h020, 32'h8000_0000, 32'h0, 32'h0, 1'b1);
    sh(1'b0, 12'h240, 32'h8000_0018, 32'h0, 32'hf800_0001, 1'b1);
    sh(1'b0, 12'h260, 32'h0000_0018, 32'h0, 32'h8000_0001, 1'b1);
    sh(1'b0, 12'h060, 32'h0000_0003, 32'h0, 32'h8000_0001, 1'b1);
    sh(1'b0, 12'h210, 32'h0000_0005, 32'h0000_0100, 32'h5, 1'b1);
    sh(1'b0, 12'h210, 32'h0000_0001, 32'h0000_0020, 32'h0, 1'b1);
    sh(1'b0, 12'h230, 32'hffff_ffff, 32'h0000_0021, 32'h0, 1'b0);
    sh(1'b0, 12'h230, 32'h0000_0018, 32'h0000_0004, 32'h1, 1'b1);
    sh(1'b0, 12'h270, 32'h0000_0018, 32'h0000_0024, 32'h8000_0001, 1'b1);
    sh(1'b0, 12'h250, 32'h8000_0000, 32'h0000_0028, 32'hffff_ffff, 1'b1);
    sh(1'b1, 12'h4ab, 32'h0, 32'h0, 32'hab00_0000, 1'b1);
    ex({4'he, 3'b000, 4'b1101, 1'b1, 4'h0, 4'h3, 12'hf10}, 32'h0, 32'h1, 32'h4);
    chk("shift reg pc", got.wr_en, 1'b0);
    rd(BAS_OFS_STAT, rv); chk("stat error", rv, 32'h0000_0003);
    wr(BAS_OFS_STAT, 32'h0000_0002);
    rd(BAS_OFS_STAT, rv); chk("stat clear", rv, 32'h0000_0001);
    ex({4'he, 4'b1011, 24'hff_fffe}, 32'h0, 32'h0, 32'h0);
    chk("target back", got.target, 32'h0000_1000);
    chk("link", got.link, 32'h0000_1004);
    chk("link en", got.link_en, 1'b1);
    ex({4'he, 4'b1010, 24'h00_0010}, 32'h0, 32'h0, 32'h0);
    chk("target fwd", got.target, 32'h0000_1048);
    chk("no link", got.link_en, 1'b0);
    for (int k = 0; k < 2; k++) begin
      for (int cc = 0; cc < 16; cc++) begin
        wr(BAS_OFS_CSW, k == 1 ? 32'h9000_00d3 : 32'h6000_00d3);
        ex({cc[3:0], 4'b1010, 24'h00_0001}, 32'h0, 32'h0, 32'h0);
        chk("condition", got.jump, cond_ok(cc[3:0], k == 1 ? 4'b1001 : 4'b0110));
      end
    end
    wr(BAS_OFS_SSW, 32'h5000_0010);
    for (int s = 1; s >= 0; s--) begin
      wr(BAS_OFS_CSW, 32'h2000_00d3);
      ex({4'he, 3'b001, 4'b1101, s[0], 4'h0, 4'hf, 12'h0ab}, 32'h0, 32'h0, 32'h0);
      chk("pc target", got.target, 32'h0000_00ab);
      chk("status restore", csw, s == 1 ? 32'h5000_0010 : 32'h2000_00d3);
    end
    give_verdict;
  end
endmodule
`default_nettype wire
